// File: vgs_consts.svh
// Constant definitions for the VGA general control and status port block.
`ifndef VGS_CONSTS_SVH
`define VGS_CONSTS_SVH
`define VGS_ADDR_STAT0_MISC_WR 16'h03C2
`define VGS_ADDR_STAT1_MONO 16'h03BA
`define VGS_ADDR_STAT1_COLOR 16'h03DA
`define VGS_ADDR_FEAT_RD 16'h03CA
`define VGS_ADDR_MISC_RD 16'h03CC
`define VGS_MISC_RESET 8'h00
`define VGS_FEAT_RESET 8'h00
`define VGS_MISC_IOSEL_BIT 0
`define VGS_FEAT_VSYNC_OR_BIT 3
`define VGS_FEAT_MASK 8'h08
`define VGS_MISC_MASK 8'hEF
`define VGS_ST0_IRQ_BIT 7
`define VGS_ST0_SENSE_BIT 4
`define VGS_ST1_VSYNC_BIT 7
`define VGS_ST1_FB1_BIT 5
`define VGS_ST1_FB0_BIT 4
`define VGS_ST1_VRTR_BIT 3
`define VGS_ST1_DE_BIT 0
`define VGS_VRE_CLR_N_BIT 4
`define VGS_VRE_DIS_BIT 5
`define VGS_ST0_RSVD_MASK 8'h6F
`define VGS_ST1_RSVD_MASK 8'h46
`endif

// File: vgs_pkg.sv
// Types shared by the VGA general control and status port block.
package vgs_pkg;
	typedef struct packed {
		logic vsync; // Raw vertical sync from the timing generator.
		logic hretrace; // Horizontal retrace interval in progress.
		logic vretrace; // Vertical retrace interval in progress.
		logic dac_sense; // DAC comparator output.
	} vgs_timing_s;
	typedef struct packed {
		logic rd; // One-cycle read strobe.
		logic wr; // One-cycle write strobe.
		logic [15:0] addr; // I/O port address.
		logic [7:0] wdata; // Write data.
	} vgs_io_req_s;
endpackage : vgs_pkg

// File: vgs_status_regs.sv
// Directly addressed VGA input status, feature control and misc output ports.
`timescale 1ns/1ns
`include "vgs_consts.svh"
// Overview of operation
// - All four ports decoded directly, no index
// - Status zero read-only at 3C2
// - Status one read at 3BA or 3DA
// - Misc bit 0 selects mono or color range
// - Feature control read 3CA, written 3BA/3DA
// - Misc output read 3CC, written 3C2
// - Status zero bit 7 shows pending interrupt
// - Interrupt raised at vertical retrace start, gated
// - Status zero bit 4 shows DAC sense
// - Status one bit 7 shows VSYNC pin
// - Feature bit 3 ORs display enable into VSYNC
// - Status one bits 5-4 mirror selected colour bits
// - Status one bit 3 is vertical retrace
// - Status one bit 0 is any retrace
// - Horizontal retrace spans whole blank line part
// - Vertical retrace spans all non-active lines
module vgs_status_regs (
	input wire logic ref_clk, // 250 MHz clock.
	input wire logic rst, // Synchronous active-high reset.
	input wire vgs_pkg::vgs_io_req_s io_req, // Host I/O request.
	input wire vgs_pkg::vgs_timing_s timing, // Timing generator status, pixel domain.
	input wire logic [7:0] palette_color, // Colour bits sent to palette, pixel domain.
	input wire logic [1:0] plane_fb_sel, // Colour plane enable bits 5:4.
	input wire logic [7:0] vretrace_end_ctrl, // Vertical retrace end control register.
	output logic [7:0] io_rdata_reg, // Read data, valid the cycle after rd.
	output logic io_rvalid_reg, // Pulse: read data valid.
	output logic vsync_pin_reg, // VSYNC output pin.
	output logic irq_pending_reg, // Retrace interrupt pending.
	output logic [7:0] misc_output_reg, // Misc output register contents.
	output logic [7:0] feature_control_reg // Feature control register contents.
);
	// ============================================================
	// Synchronisers
	// ============================================================
	// Every pixel-domain level passes two flops; the first is read only by the second.
	logic [11:0] sync1_reg;
	logic [11:0] sync2_reg;
	logic vret_prev_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
		end else begin
			sync1_reg <= {timing.vsync, timing.hretrace, timing.vretrace, timing.dac_sense, palette_color};
			sync2_reg <= sync1_reg;
		end
	end
	logic s_vsync, s_hret, s_vret, s_sense;
	logic [7:0] s_color;
	assign {s_vsync, s_hret, s_vret, s_sense, s_color} = sync2_reg;

	// ============================================================
	// Address decode
	// ============================================================
	// The mono/color window follows the live misc register bit.
	logic color_sel;
	logic st1_hit;
	assign color_sel = misc_output_reg[`VGS_MISC_IOSEL_BIT];
	assign st1_hit = color_sel ? (io_req.addr == `VGS_ADDR_STAT1_COLOR)
		: (io_req.addr == `VGS_ADDR_STAT1_MONO);

	// Fixed port match for the hit signals the checks use; the read mux compares the address directly.
	function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
		port_hit = (addr == port);
	endfunction : port_hit
	logic st0_hit;
	logic feat_rd_hit;
	logic misc_rd_hit;
	logic mapped_rd;
	assign st0_hit = port_hit(io_req.addr, `VGS_ADDR_STAT0_MISC_WR);
	assign feat_rd_hit = port_hit(io_req.addr, `VGS_ADDR_FEAT_RD);
	assign misc_rd_hit = port_hit(io_req.addr, `VGS_ADDR_MISC_RD);
	assign mapped_rd = st0_hit | st1_hit | feat_rd_hit | misc_rd_hit;

	// ============================================================
	// Writable registers
	// ============================================================
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			misc_output_reg <= `VGS_MISC_RESET;
		end else if (io_req.wr && io_req.addr == `VGS_ADDR_STAT0_MISC_WR) begin
			misc_output_reg <= io_req.wdata & `VGS_MISC_MASK;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			feature_control_reg <= `VGS_FEAT_RESET;
		end else if (io_req.wr && st1_hit) begin
			feature_control_reg <= io_req.wdata & `VGS_FEAT_MASK;
		end
	end

	// ============================================================
	// Status composition
	// ============================================================
	logic disp_en;
	logic [1:0] fb_bits;
	assign disp_en = s_hret | s_vret;
	always_comb begin
		unique case (plane_fb_sel)
			2'h0: fb_bits = {s_color[4], s_color[0]};
			2'h1: fb_bits = {s_color[5], s_color[1]};
			2'h2: fb_bits = {s_color[3], s_color[2]};
			2'h3: fb_bits = {s_color[7], s_color[6]};
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			vsync_pin_reg <= 1'b0;
		end else begin
			vsync_pin_reg <= feature_control_reg[`VGS_FEAT_VSYNC_OR_BIT] ? (s_vsync | disp_en) : s_vsync;
		end
	end

	// ============================================================
	// Retrace interrupt
	// ============================================================
	// Bit 4 low clears and holds clear; bit 5 high stops new events.
	// A new retrace start wins over the clear, even though clear is a held level.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			vret_prev_reg <= 1'b0;
		end else begin
			vret_prev_reg <= s_vret;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_pending_reg <= 1'b0;
		end else if (s_vret && !vret_prev_reg && !vretrace_end_ctrl[`VGS_VRE_DIS_BIT]) begin
			irq_pending_reg <= 1'b1;
		end else if (!vretrace_end_ctrl[`VGS_VRE_CLR_N_BIT]) begin
			irq_pending_reg <= 1'b0;
		end
	end

	// ============================================================
	// Read port
	// ============================================================
	logic [7:0] rdata_next;
	always_comb begin
		rdata_next = 8'h00;
		if (io_req.addr == `VGS_ADDR_STAT0_MISC_WR) begin
			rdata_next[`VGS_ST0_IRQ_BIT] = irq_pending_reg;
			rdata_next[`VGS_ST0_SENSE_BIT] = s_sense;
		end else if (st1_hit) begin
			rdata_next[`VGS_ST1_VSYNC_BIT] = vsync_pin_reg;
			rdata_next[`VGS_ST1_FB1_BIT] = fb_bits[1];
			rdata_next[`VGS_ST1_FB0_BIT] = fb_bits[0];
			rdata_next[`VGS_ST1_VRTR_BIT] = s_vret;
			rdata_next[`VGS_ST1_DE_BIT] = disp_en;
		end else if (io_req.addr == `VGS_ADDR_FEAT_RD) begin
			rdata_next = feature_control_reg;
		end else if (io_req.addr == `VGS_ADDR_MISC_RD) begin
			rdata_next = misc_output_reg;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			io_rdata_reg <= 8'h00;
			io_rvalid_reg <= 1'b0;
		end else begin
			io_rvalid_reg <= io_req.rd;
			if (io_req.rd) begin
				io_rdata_reg <= rdata_next;
			end
		end
	end

	// ============================================================
	// Register file checks
	// ============================================================
	// A write to the status zero port belongs to misc output only.
	status_wr_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.wr && st0_hit && !st1_hit |=> feature_control_reg == $past(feature_control_reg))
		else $error("status zero write disturbed feature control");

	// The reserved misc bit is dropped on the way in.
	misc_write_lands_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.wr && st0_hit
		|=> misc_output_reg == ($past(io_req.wdata) & `VGS_MISC_MASK))
		else $error("misc output write lost");

	// Misc output only moves on its own write port.
	misc_held_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(io_req.wr && st0_hit) |=> misc_output_reg == $past(misc_output_reg))
		else $error("misc output changed without a write");

	// The reserved misc bit must never be stored.
	misc_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |-> (misc_output_reg & ~`VGS_MISC_MASK) == 8'h00)
		else $error("misc output reserved bit set");

	// A write to the active status one port lands in feature control.
	feat_write_lands_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.wr && st1_hit |=> feature_control_reg == ($past(io_req.wdata) & `VGS_FEAT_MASK))
		else $error("feature control write lost");

	// Writes outside the active window must not reach feature control.
	feat_window_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.wr && !st1_hit |=> feature_control_reg == $past(feature_control_reg))
		else $error("feature control written from inactive window");

	// Only the sync control bit of feature control is kept.
	feat_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |-> (feature_control_reg & ~`VGS_FEAT_MASK) == 8'h00)
		else $error("feature control reserved bit set");

	// Reset leaves every output quiet.
	reset_quiet_a: assert property (@(posedge ref_clk)
		rst |=> io_rdata_reg == 8'h00 && !io_rvalid_reg && !irq_pending_reg && !vsync_pin_reg
		&& misc_output_reg == `VGS_MISC_RESET && feature_control_reg == `VGS_FEAT_RESET)
		else $error("outputs not cleared by reset");

	// ============================================================
	// Read port checks
	// ============================================================
	// Feature control reads back on its own read port.
	feat_read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
		feat_rd_hit && io_req.rd |=> io_rvalid_reg && io_rdata_reg == $past(feature_control_reg))
		else $error("feature control readback wrong");

	// Misc output reads back on its own read port.
	misc_read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
		misc_rd_hit && io_req.rd |=> io_rvalid_reg && io_rdata_reg == $past(misc_output_reg))
		else $error("misc output readback wrong");

	// Every read is answered exactly one cycle later.
	rvalid_follows_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd |=> io_rvalid_reg)
		else $error("read not answered");

	// The valid flag is a pulse, never raised without a read.
	rvalid_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		!io_req.rd |=> !io_rvalid_reg)
		else $error("read valid without a read");

	// Read data stands until the next read.
	rdata_held_a: assert property (@(posedge ref_clk) disable iff (rst)
		!io_req.rd |=> $stable(io_rdata_reg))
		else $error("read data changed without a read");

	// Addresses outside the four ports read as zero.
	unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && !mapped_rd
		|=> io_rvalid_reg && io_rdata_reg == 8'h00)
		else $error("unmapped read returned data");

	// The color window is dead while the mono range is selected.
	st1_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && !color_sel && io_req.addr == `VGS_ADDR_STAT1_COLOR |=> io_rdata_reg == 8'h00)
		else $error("color window answered in mono mode");

	// The mono window is dead while the color range is selected.
	mono_window_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && color_sel && io_req.addr == `VGS_ADDR_STAT1_MONO |=> io_rdata_reg == 8'h00)
		else $error("mono window answered in color mode");

	// Status one answers at the color port while that range is selected.
	st1_color_window_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && color_sel && io_req.addr == `VGS_ADDR_STAT1_COLOR
		|=> io_rvalid_reg && io_rdata_reg[`VGS_ST1_VRTR_BIT] == $past(s_vret))
		else $error("status one missing at color port");

	// ============================================================
	// Status content checks
	// ============================================================
	// The pending flag is shown as it stood when the read was taken.
	st0_irq_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st0_hit |=> io_rdata_reg[`VGS_ST0_IRQ_BIT] == $past(irq_pending_reg))
		else $error("status zero interrupt bit wrong");

	// The comparator sense is shown after synchronisation.
	st0_sense_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st0_hit |=> io_rdata_reg[`VGS_ST0_SENSE_BIT] == $past(s_sense))
		else $error("status zero sense bit wrong");

	// Reserved status zero bits read as zero.
	st0_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st0_hit |=> (io_rdata_reg & `VGS_ST0_RSVD_MASK) == 8'h00)
		else $error("status zero reserved bits set");

	// The sync bit reports the pin as driven, not the raw sync.
	st1_vsync_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st1_hit |=> io_rdata_reg[`VGS_ST1_VSYNC_BIT] == $past(vsync_pin_reg))
		else $error("status one sync bit wrong");

	// The feedback pair follows the selected colour bits.
	st1_feedback_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st1_hit |=> io_rdata_reg[`VGS_ST1_FB1_BIT] == $past(fb_bits[1])
		&& io_rdata_reg[`VGS_ST1_FB0_BIT] == $past(fb_bits[0]))
		else $error("status one feedback bits wrong");

	// Retrace bits: vertical alone, and either interval combined.
	st1_retrace_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st1_hit |=> io_rdata_reg[`VGS_ST1_DE_BIT] == ($past(s_hret) | $past(s_vret))
		&& io_rdata_reg[`VGS_ST1_VRTR_BIT] == $past(s_vret))
		else $error("retrace status bits wrong");

	// Reserved status one bits read as zero.
	st1_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
		io_req.rd && st1_hit |=> (io_rdata_reg & `VGS_ST1_RSVD_MASK) == 8'h00)
		else $error("status one reserved bits set");

	// ============================================================
	// Pin and interrupt checks
	// ============================================================
	// With the control bit clear the pin carries plain sync.
	vsync_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
		!feature_control_reg[`VGS_FEAT_VSYNC_OR_BIT] |=> vsync_pin_reg == $past(s_vsync))
		else $error("vsync pin does not follow sync");

	// With the control bit set the retrace status is merged onto the pin.
	vsync_or_a: assert property (@(posedge ref_clk) disable iff (rst)
		feature_control_reg[`VGS_FEAT_VSYNC_OR_BIT] |=> vsync_pin_reg == ($past(s_vsync) | $past(disp_en)))
		else $error("vsync pin misses display enable");

	// The start of retrace sets the flag even while a clear is held.
	irq_on_start_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_vret && !vret_prev_reg && !vretrace_end_ctrl[`VGS_VRE_DIS_BIT] |=> irq_pending_reg)
		else $error("retrace interrupt not raised");

	// No flag without an enabled retrace start.
	irq_no_spurious_a: assert property (@(posedge ref_clk) disable iff (rst)
		!irq_pending_reg && !(s_vret && !vret_prev_reg && !vretrace_end_ctrl[`VGS_VRE_DIS_BIT]) |=> !irq_pending_reg)
		else $error("retrace interrupt raised without cause");

	// A held clear drops the flag unless a new start arrives.
	irq_cleared_a: assert property (@(posedge ref_clk) disable iff (rst)
		!vretrace_end_ctrl[`VGS_VRE_CLR_N_BIT] && !(s_vret && !vret_prev_reg) |=> !irq_pending_reg)
		else $error("retrace interrupt not cleared");

	// Without a clear the flag stays pending.
	irq_held_a: assert property (@(posedge ref_clk) disable iff (rst)
		irq_pending_reg && vretrace_end_ctrl[`VGS_VRE_CLR_N_BIT] |=> irq_pending_reg)
		else $error("retrace interrupt lost");

endmodule : vgs_status_regs

// File: vgs_host_model.sv
// Host CPU model issuing I/O port reads and writes.
`timescale 1ns/1ns
module vgs_host_model (
	input wire logic ref_clk, // Bus clock.
	output vgs_pkg::vgs_io_req_s io_req, // Request to the port block.
	input wire logic [7:0] io_rdata_reg, // Read data.
	input wire logic io_rvalid_reg // Read data valid.
);
	initial io_req = '0;
	// ==========
	// Bus cycles
	// The address is inverted on release so stale values never look valid.
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(negedge ref_clk);
		io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(negedge ref_clk);
		io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge ref_clk);
		io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
		v = (io_rvalid_reg === 1'b1) ? io_rdata_reg : 8'hXX;
	endtask : rd
endmodule : vgs_host_model

// File: vga_input_status_regs_test.sv
// Self-checking bench for the VGA status port block.
`timescale 1ns/1ns
module vga_input_status_regs_test;
	logic ref_clk;
	logic rst;
	vgs_pkg::vgs_io_req_s io_req;
	vgs_pkg::vgs_timing_s timing;
	logic [7:0] palette_color;
	logic [1:0] plane_fb_sel;
	logic [7:0] vretrace_end_ctrl;
	logic [7:0] io_rdata_reg;
	logic io_rvalid_reg;
	logic [7:0] d;
	int n_mismatch;
	int tests_run;
	int cycles;
	vgs_status_regs i_vgs_status_regs (.ref_clk(ref_clk), .rst(rst), .io_req(io_req), .timing(timing),
		.palette_color(palette_color), .plane_fb_sel(plane_fb_sel), .vretrace_end_ctrl(vretrace_end_ctrl),
		.io_rdata_reg(io_rdata_reg), .io_rvalid_reg(io_rvalid_reg), .vsync_pin_reg(), .irq_pending_reg(),
		.misc_output_reg(), .feature_control_reg());
	vgs_host_model i_vgs_host_model (.ref_clk(ref_clk), .io_req(io_req), .io_rdata_reg(io_rdata_reg),
		.io_rvalid_reg(io_rvalid_reg));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ==========
	// Helpers
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		i_vgs_host_model.rd(a, d);
		tests_run++;
		if (d !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, d, e);
		end
	endtask : rdchk
	// Waits past the two-flop synchroniser and the pin register.
	task automatic setw(input logic [3:0] t, input logic [7:0] c);
		@(negedge ref_clk);
		timing = t;
		vretrace_end_ctrl = c;
		repeat (8) @(posedge ref_clk);
	endtask : setw
	// ==========
	// Scenarios
	task automatic t_regs;
		rdchk(16'h03DA, 8'h00);
		rdchk(16'h03CC, 8'h00);
		rdchk(16'h03CA, 8'h00);
		i_vgs_host_model.wr(16'h03C2, 8'hFF);
		rdchk(16'h03CC, 8'hEF);
		i_vgs_host_model.wr(16'h03DA, 8'h08);
		rdchk(16'h03CA, 8'h08);
		i_vgs_host_model.wr(16'h03BA, 8'h00);
		rdchk(16'h03CA, 8'h08);
		rdchk(16'h03BA, 8'h00);
		rdchk(16'h03C0, 8'h00);
		i_vgs_host_model.wr(16'h03DA, 8'h00);
	endtask : t_regs
	task automatic t_status;
		setw(4'b0000, 8'h00);
		rdchk(16'h03DA, 8'h00);
		setw(4'b0100, 8'h00);
		rdchk(16'h03DA, 8'h01);
		setw(4'b0010, 8'h00);
		rdchk(16'h03DA, 8'h09);
		setw(4'b1010, 8'h00);
		rdchk(16'h03DA, 8'h89);
		setw(4'b0010, 8'h00);
		rdchk(16'h03DA, 8'h09);
		i_vgs_host_model.wr(16'h03DA, 8'h08);
		setw(4'b0010, 8'h00);
		rdchk(16'h03DA, 8'h89);
		i_vgs_host_model.wr(16'h03DA, 8'h00);
	endtask : t_status
	task automatic t_irq;
		setw(4'b0001, 8'h10);
		rdchk(16'h03C2, 8'h10);
		setw(4'b0011, 8'h10);
		rdchk(16'h03C2, 8'h90);
		setw(4'b0011, 8'h00);
		rdchk(16'h03C2, 8'h10);
		setw(4'b0001, 8'h30);
		setw(4'b0011, 8'h30);
		rdchk(16'h03C2, 8'h10);
	endtask : t_irq
	task automatic t_feedback;
		logic [7:0] pal [4];
		pal = '{8'h11, 8'h22, 8'h0C, 8'hC0};
		for (int s = 0; s < 4; s++) begin
			plane_fb_sel = s[1:0];
			palette_color = pal[s];
			setw(4'b0000, 8'h00);
			rdchk(16'h03DA, 8'h30);
		end
	endtask : t_feedback
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		rst = 1'b1;
		timing = '0;
		palette_color = 8'h00;
		plane_fb_sel = 2'h0;
		vretrace_end_ctrl = 8'h00;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_regs();
		t_status();
		t_irq();
		t_feedback();
		conclude();
	end
endmodule : vga_input_status_regs_test
